// ===== core/pobt_translate.sv
/*
 Outbound address translation stage: matches client requests against
 translation regions, remaps memory requests, and charges flow credit.
 Assumes regions are set up by configuration logic at the same clock and
 that the downstream link path accepts one request per ready cycle.
*/
// Notes on behaviour
// (RULE1) Completions leave with their address untranslated, whatever the client bus holds.
// (RULE2) Message TLPs are never translated, even if header words hit a region.
// (RULE3) Completions never decrement the credit counter named by a matching region.
// (RULE4) Client address is zero during completions, so zero-based regions would hit.
// (RULE5) Software starts every region at 0x1000 or above, never at zero.
// (RULE6) Initiators use each 256MiB window only from base plus 4KB.
// (RULE7) Memory requests inside an enabled region become target plus offset.
`default_nettype none
module pobt_translate
	import pobt_pkg::*;
#(
	parameter int NREG = NUM_REGION
) (
	// Clock and reset
	input  wire  logic                   mclk,
	input  wire  logic                   sys_rst,
	// Region configuration
	input  wire  pobt_region_t [NREG-1:0] regions,
	// Client request
	input  wire  logic                   reqValid,
	output logic                         reqReady,
	input  wire  pobt_req_t              req,
	// Link side
	output logic                         outValid,
	input  wire  logic                   outReady,
	output pobt_req_t                    outReq,
	output logic                         outTranslated,
	// Credit return from link and current counts
	input  wire  logic [2:0]             creditReturn,
	output logic [2:0][CREDIT_W-1:0]     creditCount,
	output logic                         cfgError
);
	logic [NREG-1:0]             hitVec;
	logic [NREG-1:0][ADDR_W-1:0] mapVec;
	logic                        anyHit;
	logic [ADDR_W-1:0]           hitAddr;
	pobt_credit_t                hitCredit;
	logic                        mayXlate;
	logic                        take;

	logic                        outValid_r, outValid_nxt;
	pobt_req_t                   outReq_r, outReq_nxt;
	logic                        outXl_r, outXl_nxt;
	logic [2:0][CREDIT_W-1:0]    cred_r, cred_nxt;
	logic                        cfgErr_r, cfgErr_nxt;

	genvar gi;
	generate
		for (gi = 0; gi < NREG; gi++) begin : g_region
			pobt_region_match u_match (
				.region (regions[gi]),
				.addr   (req.addr),
				.hit    (hitVec[gi]),
				.mapped (mapVec[gi])
			);
		end
	endgenerate

	// Lowest-numbered hit wins
	always_comb begin
		anyHit    = 1'b0;
		hitAddr   = req.addr;
		hitCredit = POBT_CR_POSTED;
		for (int i = NREG - 1; i >= 0; i--) begin
			if (hitVec[i]) begin
				anyHit    = 1'b1;
				hitAddr   = mapVec[i];
				hitCredit = regions[i].credit;
			end
		end
	end

	assign reqReady = !outValid_r || outReady;
	assign take     = reqValid && reqReady;
	// Only address-routed memory requests may be remapped
	assign mayXlate = (req.kind == POBT_KIND_MEM) && anyHit; // [RULE1] [RULE2]

	always_comb begin
		outValid_nxt = outValid_r;
		outReq_nxt   = outReq_r;
		outXl_nxt    = outXl_r;
		cred_nxt     = cred_r;
		cfgErr_nxt   = cfgErr_r;
		if (outValid_r && outReady) begin
			outValid_nxt = 1'b0;
		end
		// A return and a charge in one cycle net out; counters wrap at eight bits
		for (int c = 0; c < 3; c++) begin
			if (creditReturn[c]) begin
				cred_nxt[c] = cred_nxt[c] + 1'b1;
			end
		end
		if (take) begin
			outValid_nxt = 1'b1;
			outReq_nxt   = req;
			outXl_nxt    = mayXlate;
			if (mayXlate) begin
				outReq_nxt.addr = hitAddr; // [RULE7]
			end
			// Region credit charged only for translated requests, never completions
			if (mayXlate && req.kind != POBT_KIND_CPL) begin // [RULE3] [RULE4]
				cred_nxt[hitCredit] = cred_nxt[hitCredit] - 1'b1;
			end
		end
		// Sticky until reset: a region at zero would catch completions and messages
		for (int r = 0; r < NREG; r++) begin
			if (regions[r].enable && regions[r].base < REGION_MIN_BASE) begin
				cfgErr_nxt = 1'b1; // [RULE5]
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			outValid_r <= 1'b0;
			outReq_r   <= '0;
			outXl_r    <= 1'b0;
			cred_r     <= {3{CREDIT_RESET}};
			cfgErr_r   <= 1'b0;
		end else begin
			outValid_r <= outValid_nxt;
			outReq_r   <= outReq_nxt;
			outXl_r    <= outXl_nxt;
			cred_r     <= cred_nxt;
			cfgErr_r   <= cfgErr_nxt;
		end
	end

	assign outValid      = outValid_r;
	assign outReq        = outReq_r;
	assign outTranslated = outXl_r;
	assign creditCount   = cred_r;
	assign cfgError      = cfgErr_r;

	// Checks
	property p_cplNoXlate;
		@(posedge mclk) disable iff (sys_rst)
		take && req.kind == POBT_KIND_CPL |=> !outTranslated && outReq.addr == $past(req.addr);
	endproperty
	a_cplNoXlate: assert property (p_cplNoXlate) else $error("completion translated"); // [RULE1]

	property p_msgNoXlate;
		@(posedge mclk) disable iff (sys_rst)
		take && req.kind == POBT_KIND_MSG && anyHit |=> !outTranslated;
	endproperty
	a_msgNoXlate: assert property (p_msgNoXlate) else $error("message translated"); // [RULE2]

	property p_cplNoCredit;
		@(posedge mclk) disable iff (sys_rst)
		take && req.kind == POBT_KIND_CPL && creditReturn == 3'h0 |=> $stable(creditCount);
	endproperty
	a_cplNoCredit: assert property (p_cplNoCredit) else $error("completion charged credit"); // [RULE3]

	property p_zeroCpl;
		@(posedge mclk) disable iff (sys_rst)
		take && req.kind == POBT_KIND_CPL && req.addr == CLIENT_ADDR_CPL
			|=> outReq.addr == CLIENT_ADDR_CPL;
	endproperty
	a_zeroCpl: assert property (p_zeroCpl) else $error("zero completion address altered"); // [RULE4]

	property p_memXlate;
		@(posedge mclk) disable iff (sys_rst)
		take && req.kind == POBT_KIND_MEM && anyHit |=> outTranslated && outReq.addr == $past(hitAddr);
	endproperty
	a_memXlate: assert property (p_memXlate) else $error("memory request not remapped"); // [RULE7]

	sequence s_stalled;
		outValid && !outReady;
	endsequence

	sequence s_held;
		outValid && $stable(outReq) && $stable(outTranslated);
	endsequence

	property p_holdOut;
		@(posedge mclk) disable iff (sys_rst)
		s_stalled |=> s_held;
	endproperty
	a_holdOut: assert property (p_holdOut) else $error("output dropped under stall"); // [RULE7]

	property p_cfgErr;
		@(posedge mclk) disable iff (sys_rst)
		regions[0].enable && regions[0].base < REGION_MIN_BASE |=> cfgError;
	endproperty
	a_cfgErr: assert property (p_cfgErr) else $error("zero-based region not flagged"); // [RULE5]

	property p_memCredit;
		@(posedge mclk) disable iff (sys_rst)
		take && req.kind == POBT_KIND_MEM && anyHit && creditReturn == 3'h0
			|=> creditCount[$past(hitCredit)] == $past(creditCount[hitCredit]) - 1'b1;
	endproperty
	a_memCredit: assert property (p_memCredit) else $error("memory credit not charged"); // [RULE7]

	property p_noTakeStall;
		@(posedge mclk) disable iff (sys_rst)
		outValid && !outReady |-> !reqReady;
	endproperty
	a_noTakeStall: assert property (p_noTakeStall) else $error("request taken under stall"); // [RULE7]

	property p_msgNoCredit;
		@(posedge mclk) disable iff (sys_rst)
		take && req.kind == POBT_KIND_MSG && creditReturn == 3'h0 |=> $stable(creditCount);
	endproperty
	a_msgNoCredit: assert property (p_msgNoCredit) else $error("message charged credit"); // [RULE2]

	property p_cfgSticky;
		@(posedge mclk) disable iff (sys_rst)
		cfgError |=> cfgError;
	endproperty
	a_cfgSticky: assert property (p_cfgSticky) else $error("config error flag dropped"); // [RULE5]

	// Each class counts its returns when nothing is charged
	for (genvar gc = 0; gc < 3; gc++) begin : g_credChk
		property p_credReturn;
			@(posedge mclk) disable iff (sys_rst)
			creditReturn[gc] && !take |=> creditCount[gc] == $past(creditCount[gc]) + 1'b1;
		endproperty
		a_credReturn: assert property (p_credReturn) else $error("credit return lost"); // [RULE3]
	end
endmodule
`default_nettype wire

// ===== core/pobt_pkg.sv
/*
 Shared constants and carriers for the outbound address translation stage.
 Assumes one core clock and a synchronous active-high reset in the user.
*/
`default_nettype none
package pobt_pkg;
	localparam int ADDR_W     = 64;
	localparam int NUM_REGION = 4;
	localparam int CREDIT_W   = 8;

	// Kind of outbound TLP offered by the client
	typedef enum logic [1:0] {
		POBT_KIND_MEM,
		POBT_KIND_MSG,
		POBT_KIND_CPL,
		POBT_KIND_OTHER
	} pobt_kind_t;

	// Credit class a region charges
	typedef enum logic [1:0] {
		POBT_CR_POSTED,
		POBT_CR_NONPOSTED,
		POBT_CR_CPL
	} pobt_credit_t;

	localparam logic [ADDR_W-1:0] REGION_MIN_BASE = 64'h0000_0000_0000_1000;
	localparam logic [ADDR_W-1:0] CLIENT_ADDR_CPL = 64'h0000_0000_0000_0000;
	localparam logic [ADDR_W-1:0] WINDOW_SIZE     = 64'h0000_0000_1000_0000;
	localparam logic [ADDR_W-1:0] WINDOW_GUARD    = 64'h0000_0000_0000_1000;
	localparam logic [CREDIT_W-1:0] CREDIT_RESET  = 8'h20;

	typedef struct packed {
		logic              enable;
		logic [ADDR_W-1:0] base;
		logic [ADDR_W-1:0] limit;
		logic [ADDR_W-1:0] target;
		pobt_credit_t      credit;
	} pobt_region_t;

	typedef struct packed {
		pobt_kind_t        kind;
		logic [ADDR_W-1:0] addr;
	} pobt_req_t;
endpackage
`default_nettype wire

// ===== core/pobt_region_match.sv
/*
 One translation region comparator: hit test and remapped address.
 Assumes a region configuration that is stable while requests flow.
*/
`default_nettype none
module pobt_region_match
	import pobt_pkg::*;
(
	// Configuration
	input  wire pobt_region_t         region,
	// Address under test
	input  wire logic [ADDR_W-1:0]    addr,
	// Result
	output logic                      hit,
	output logic [ADDR_W-1:0]         mapped
);
	always_comb begin
		hit    = region.enable && (addr >= region.base) && (addr <= region.limit);
		mapped = region.target + (addr - region.base); // [RULE7]
	end
endmodule
`default_nettype wire

// ===== dv/pobt_initiator.sv
/*
 Initiator model that offers outbound requests one at a time.
 Assumes the stage's ready/valid handshake on mclk.
*/
`default_nettype none
module pobt_initiator
	import pobt_pkg::*;
(
	// Handshake
	input  wire logic      mclk,
	input  wire logic      reqReady,
	output var  logic      reqValid,
	output var  pobt_req_t req
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		reqValid = 1'b0;
		req      = '0;
	end
	// Offer held until taken or for at most 20 cycles; idle bus shows the inverted address
	task automatic send(input pobt_kind_t k, input logic [ADDR_W-1:0] a, input int gap,
			output logic ok);
		int n;
		ok = 1'b0;
		repeat (gap) @(posedge mclk);
		#1;
		reqValid = 1'b1;
		req      = '{k, a};
		for (n = 0; n < 20 && !ok; n++) begin
			ok = reqReady;
			@(posedge mclk);
			#1;
		end
		reqValid = 1'b0;
		req.addr = ~a;
	endtask
endmodule
`default_nettype wire

// ===== dv/test_pobt_translate.sv
/*
 Testbench for the outbound translation stage.
 Assumes the stage answers one cycle after a taken request.
*/
`default_nettype none
module test_pobt_translate
	import pobt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic                          mclk, sys_rst, reqValid, reqReady, outValid, outReady;
	logic                          outTranslated, cfgError, ok;
	logic [2:0]                    creditReturn;
	logic [2:0][CREDIT_W-1:0]      creditCount;
	pobt_region_t [NUM_REGION-1:0] regions;
	pobt_req_t                     req, outReq;
	int                            mismatches, checked;
	pobt_translate #(.NREG(NUM_REGION)) u_dut (.mclk(mclk), .sys_rst(sys_rst),
		.regions(regions), .reqValid(reqValid), .reqReady(reqReady), .req(req),
		.outValid(outValid), .outReady(outReady), .outReq(outReq),
		.outTranslated(outTranslated), .creditReturn(creditReturn),
		.creditCount(creditCount), .cfgError(cfgError));
	pobt_initiator u_init (.mclk(mclk), .reqReady(reqReady), .reqValid(reqValid), .req(req));
	task automatic compare(input string name, input logic [ADDR_W-1:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic conclude;
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// One request, judged, then held through one stalled cycle at the link and drained
	task automatic run(input pobt_kind_t k, input logic [ADDR_W-1:0] a, ea, input logic tr,
			input int cls, input logic [CREDIT_W-1:0] ec);
		u_init.send(k, a, 1, ok);
		compare("taken", ok, 1'b1);
		compare("valid", outValid, 1'b1);
		compare("addr", outReq.addr, ea);
		compare("kind", outReq.kind, k);
		compare("translated", outTranslated, tr);
		compare("credit", creditCount[cls], ec);
		@(posedge mclk) #1;
		compare("stands", outValid, 1'b1);
		outReady = 1'b1;
		@(posedge mclk) #1;
		outReady = 1'b0;
		compare("drained", outValid, 1'b0);
		if (mismatches > 0)
			conclude();
	endtask
	task automatic test_mem;
		run(POBT_KIND_MEM, 64'h2000_1234, 64'h8_0000_0234, 1'b1, 0, 8'h1F);
		run(POBT_KIND_MEM, 64'h1000, 64'h4000_0000, 1'b1, 1, 8'h1F);
		run(POBT_KIND_MEM, 64'h3000_1000, 64'h3000_1000, 1'b0, 0, 8'h1F);
		$display("test_mem done");
	endtask
	task automatic test_msg;
		run(POBT_KIND_MSG, 64'h2000_1234, 64'h2000_1234, 1'b0, 0, 8'h1F);
		run(POBT_KIND_MSG, 64'h1000, 64'h1000, 1'b0, 1, 8'h1F);
		$display("test_msg done");
	endtask
	task automatic test_cpl;
		run(POBT_KIND_CPL, CLIENT_ADDR_CPL, 64'h0, 1'b0, 2, 8'h20);
		run(POBT_KIND_CPL, 64'h2000_1234, 64'h2000_1234, 1'b0, 0, 8'h1F);
		run(POBT_KIND_CPL, 64'h1000, 64'h1000, 1'b0, 1, 8'h1F);
		$display("test_cpl done");
	endtask
	// Region at zero: flagged, ignored by completions and messages, cleared by reset
	task automatic test_cfg;
		pobt_region_t keep;
		keep       = regions[0];
		regions[0] = '{1'b1, 64'h0, 64'hFFF, 64'h5000_0000, POBT_CR_CPL};
		run(POBT_KIND_CPL, CLIENT_ADDR_CPL, 64'h0, 1'b0, 2, 8'h20);
		run(POBT_KIND_MSG, 64'h0, 64'h0, 1'b0, 2, 8'h20);
		compare("cfgError", cfgError, 1'b1);
		creditReturn = 3'h2;
		@(posedge mclk) #1;
		creditReturn = 3'h0;
		compare("returned", creditCount[1], 8'h20);
		regions[0] = keep;
		sys_rst    = 1'b1;
		repeat (2) @(posedge mclk);
		#1;
		sys_rst = 1'b0;
		compare("cfgError", cfgError, 1'b0);
		compare("credit", creditCount[0], CREDIT_RESET);
		run(POBT_KIND_MEM, 64'h2000_1234, 64'h8_0000_0234, 1'b1, 0, 8'h1F);
		$display("test_cfg done");
	endtask
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	initial begin
		mismatches   = 0;
		checked      = 0;
		sys_rst      = 1'b1;
		outReady     = 1'b0;
		creditReturn = 3'h0;
		regions      = '0;
		regions[0]   = '{1'b1, 64'h2000_1000, 64'h2FFF_FFFF, 64'h8_0000_0000,
			POBT_CR_POSTED};
		regions[1]   = '{1'b1, 64'h1000, 64'hFFFF, 64'h4000_0000, POBT_CR_NONPOSTED};
		repeat (20) @(posedge mclk);
		#1;
		sys_rst = 1'b0;
		compare("cfgError", cfgError, 1'b0);
		test_mem();
		test_msg();
		test_cpl();
		test_cfg();
		conclude();
	end
endmodule
`default_nettype wire
